// ### pkg/ffc_regs.svh
`ifndef FFC_REGS_SVH
`define FFC_REGS_SVH
`define FFC_BIAS_SP      16'h007f
`define FFC_BIAS_DP      16'h03ff
`define FFC_BIAS_XP      16'h3fff
`define FFC_EXPW_SP      8
`define FFC_EXPW_DP      11
`define FFC_EXPW_XP      15
`define FFC_FRACW_SP     23
`define FFC_FRACW_DP     52
`define FFC_FRACW_XP     63
`define FFC_BYTES_SP     4'h4
`define FFC_BYTES_DP     4'h8
`define FFC_BYTES_XP     4'ha
`define FFC_XP_INT_BIT   63
`define FFC_XP_FMSB_BIT  62
`endif

// ### pkg/ffc_pkg.sv
package ffc_pkg;
   typedef enum logic [1:0] {
      FFC_FMT_SP = 2'b00,
      FFC_FMT_DP = 2'b01,
      FFC_FMT_XP = 2'b10
   } ffc_fmt_e;
   typedef enum logic [2:0] {
      FFC_CLS_ZERO   = 3'b000,
      FFC_CLS_DENORM = 3'b001,
      FFC_CLS_NORMAL = 3'b010,
      FFC_CLS_INF    = 3'b011,
      FFC_CLS_SNAN   = 3'b100,
      FFC_CLS_QNAN   = 3'b101,
      FFC_CLS_INDEF  = 3'b110
   } ffc_cls_e;
   // Unpacked operand: significand has the integer bit at bit 63.
   typedef struct packed {
      logic        sign;
      logic [15:0] exp_unb;
      logic [63:0] signif;
   } ffc_unp_s;
   typedef struct packed {
      logic [79:0] data;
      logic [3:0]  nbytes;
   } ffc_mem_s;
endpackage

// ### rtl/ffc_codec.sv
`timescale 1ns/10ps
`default_nettype none
`include "ffc_regs.svh"
// Summary of operation
// - Exponents are stored biased by 127, 1023 or 16383 per format.
// - Single and double words omit the integer bit, restored on unpack.
// - All-ones exponent with nonzero fraction and fraction MSB 0 is SNaN.
// - Memory images are 4, 8 or 10 consecutive bytes per format.
// - Extended keeps the integer bit at 63, top fraction bit at 62.
// - Restored integer bit is 1 except for zero and denormals.
module ffc_codec #(
   parameter int SP_BYTES = `FFC_BYTES_SP, // Single image size, bytes.
   parameter int DP_BYTES = `FFC_BYTES_DP, // Double image size, bytes.
   parameter int XP_BYTES = `FFC_BYTES_XP  // Extended image size, bytes.
) (
   input  wire logic            clock_in,    // Core clock.
   input  wire logic            resetn_in,   // Async reset, active low.
   input  wire logic            unpack_in,   // Pulse: unpack mem_in.
   input  wire ffc_pkg::ffc_fmt_e fmt_in,    // Operand format.
   input  wire logic [79:0]     mem_in,      // Stored word, low aligned.
   input  wire logic            pack_in,     // Pulse: pack unp_in.
   input  wire ffc_pkg::ffc_unp_s unp_in,    // Unbiased operand.
   output var  ffc_pkg::ffc_unp_s unp_out,   // Unpacked result.
   output var  ffc_pkg::ffc_cls_e cls_out,   // Class of unpacked operand.
   output var  logic            unp_vld_out, // Unpack result valid pulse.
   output var  ffc_pkg::ffc_mem_s mem_out,   // Packed image and size.
   output var  logic            pack_vld_out // Pack result valid pulse.
);
   import ffc_pkg::*;

   // The field slicing is fixed by the three formats, so an image size
   // that differs from the packed width of its format cannot be served.
   if (SP_BYTES != `FFC_BYTES_SP) begin : g_bad_sp
      $error("single image size must be 4 bytes");
   end
   if (DP_BYTES != `FFC_BYTES_DP) begin : g_bad_dp
      $error("double image size must be 8 bytes");
   end
   if (XP_BYTES != `FFC_BYTES_XP) begin : g_bad_xp
      $error("extended image size must be 10 bytes");
   end

   localparam int NFMT = 3;

   // Per-format fields, indexed 0 single, 1 double, 2 extended.
   wire logic        f_sign [NFMT];
   wire logic [15:0] f_exp  [NFMT];
   wire logic [62:0] f_frac [NFMT];
   wire logic        f_ones [NFMT];
   wire logic [15:0] f_bias [NFMT];
   wire logic [79:0] f_img  [NFMT];
   wire logic [3:0]  f_size [NFMT];

   // A cleared integer bit on the pack side means zero or denormal.
   wire logic p_den = !unp_in.signif[63];

   for (genvar gi = 0; gi < NFMT; gi++) begin : g_fmt
      localparam int EW = (gi == 0) ? `FFC_EXPW_SP :
                          (gi == 1) ? `FFC_EXPW_DP :
                          `FFC_EXPW_XP;
      localparam int FW = (gi == 0) ? `FFC_FRACW_SP :
                          (gi == 1) ? `FFC_FRACW_DP :
                          `FFC_FRACW_XP;
      // Only the extended word stores its integer bit, which sits
      // between the exponent and the fraction.
      localparam int IB = (gi == 2) ? 1 : 0;
      localparam int SB = EW + IB + FW;
      localparam logic [15:0] BIAS = (gi == 0) ? `FFC_BIAS_SP :
                                     (gi == 1) ? `FFC_BIAS_DP :
                                     `FFC_BIAS_XP;
      localparam int NB = (gi == 0) ? SP_BYTES :
                          (gi == 1) ? DP_BYTES :
                          XP_BYTES;

      // Unpack side: slice the stored word, fraction left aligned.
      wire logic [EW-1:0] u_exp  = mem_in[SB-1 -: EW];
      wire logic [FW-1:0] u_frac = mem_in[FW-1:0];
      assign f_sign[gi] = mem_in[SB];
      assign f_exp[gi]  = 16'(u_exp);
      assign f_frac[gi] = 63'(u_frac) << (63 - FW);
      assign f_ones[gi] = &u_exp;
      assign f_bias[gi] = BIAS;
      assign f_size[gi] = 4'(NB);

      // Pack side: bias the exponent, then truncate it to the field.
      wire logic [15:0] p_exp = unp_in.exp_unb + BIAS;
      // Extended keeps an explicit integer bit, so a cleared one only
      // forces a zero exponent field at the minimum exponent.
      wire logic p_zero = (IB == 1) ?
                          (p_den && unp_in.exp_unb == 16'h0001 - BIAS) :
                          p_den;
      wire logic [EW-1:0] p_field = p_zero ? '0 : p_exp[EW-1:0];
      if (IB == 1) begin : g_explicit
         assign f_img[gi] = {unp_in.sign,
                             p_field,
                             unp_in.signif};
      end else begin : g_implicit
         // The integer bit is dropped; the fraction is its top bits.
         assign f_img[gi] = 80'({unp_in.sign,
                                 p_field,
                                 unp_in.signif[62 -: FW]});
      end
   end

   // Format index; the unused code is served as extended.
   wire logic [1:0] fidx = (fmt_in == FFC_FMT_SP) ? 2'h0 :
                           (fmt_in == FFC_FMT_DP) ? 2'h1 :
                           2'h2;

   wire logic        in_sign  = f_sign[fidx];
   wire logic [15:0] in_exp   = f_exp[fidx];
   wire logic [62:0] in_frac  = f_frac[fidx];
   wire logic [15:0] in_bias  = f_bias[fidx];
   wire logic        exp_ones = f_ones[fidx];
   wire logic        xp_int   = mem_in[`FFC_XP_INT_BIT];
   wire logic exp_zero = (in_exp == 16'h0000);
   wire logic frac_nz  = |in_frac;
   wire logic frac_msb = in_frac[62];
   wire logic frac_rest_nz = |in_frac[61:0];

   // Integer bit: implied for single and double, stored for extended.
   wire logic int_bit = (fidx == 2'h2) ? xp_int :
                        !exp_zero;

   // Classes are tested in priority order. The indefinite value is also
   // a quiet NaN, so it must be recognised before the general case.
   wire logic cls_inf  = exp_ones && !frac_nz;
   wire logic cls_snan = exp_ones && frac_nz && !frac_msb;
   wire logic cls_indf = exp_ones && in_sign && frac_msb &&
                         !frac_rest_nz;
   wire logic cls_qnan = exp_ones && frac_msb;
   // An extended word with a zero exponent but its integer bit set is
   // reported as a denormal rather than a zero.
   wire logic cls_zero = exp_zero && !frac_nz && !int_bit;
   wire ffc_cls_e next_cls =
      cls_inf  ? FFC_CLS_INF :
      cls_snan ? FFC_CLS_SNAN :
      cls_indf ? FFC_CLS_INDEF :
      cls_qnan ? FFC_CLS_QNAN :
      cls_zero ? FFC_CLS_ZERO :
      exp_zero ? FFC_CLS_DENORM :
      FFC_CLS_NORMAL;

   // Denormals decode with the minimum exponent, one above the zero code.
   wire logic [15:0] eff_exp = exp_zero ? 16'h0001 : in_exp;
   wire ffc_unp_s next_unp = '{sign:    in_sign,
                               exp_unb: eff_exp - in_bias,
                               signif:  {int_bit, in_frac}};

   // Packing does no rounding: low significand bits are truncated.
   wire ffc_mem_s next_mem = '{data:   f_img[fidx],
                               nbytes: f_size[fidx]};

   // The unpack valid pulse follows its request by exactly one edge.
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         unp_vld_out <= 1'b0;
      end else begin
         unp_vld_out <= unpack_in;
      end
   end

   // The pack valid pulse follows its request by exactly one edge.
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pack_vld_out <= 1'b0;
      end else begin
         pack_vld_out <= pack_in;
      end
   end

   // The unpacked operand holds until the next unpack request.
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         unp_out <= '0;
      end else if (unpack_in) begin
         unp_out <= next_unp;
      end
   end

   // The class is taken on the same edge as the unpacked operand.
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cls_out <= FFC_CLS_ZERO;
      end else if (unpack_in) begin
         cls_out <= next_cls;
      end
   end

   // The packed image and its size hold until the next pack request.
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         mem_out <= '0;
      end else if (pack_in) begin
         mem_out <= next_mem;
      end
   end
endmodule // ffc_codec
`default_nettype wire

// ### sim/ffc_codec_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module ffc_chk (
   input wire logic              clock_in, resetn_in, unpack_in, pack_in,
   input wire ffc_pkg::ffc_fmt_e fmt_in,
   input wire logic [79:0]       mem_in,
   input wire ffc_pkg::ffc_unp_s unp_in, unp_out,
   input wire ffc_pkg::ffc_cls_e cls_out,
   input wire logic              unp_vld_out, pack_vld_out,
   input wire ffc_pkg::ffc_mem_s mem_out
);
   import ffc_pkg::*;
   default clocking @(posedge clock_in); endclocking
   default disable iff (!resetn_in);
   wire       s = unpack_in && fmt_in == FFC_FMT_SP;
   wire [7:0] e = mem_in[30:23];
   sequence nrm; s && e != 8'h00 && e != 8'hff; endsequence
   a_sp_bias: assert property (nrm |=> unp_out.exp_unb ==
      16'($past(e)) - 16'h007f) else $error("bias");
   a_sp_snan: assert property (s && e == 8'hff && !mem_in[22] &&
      mem_in[21:0] != 22'h0 |=> cls_out == FFC_CLS_SNAN) else $error("snan");
   a_mem_size: assert property (pack_in |=> mem_out.nbytes == (
      $past(fmt_in) == FFC_FMT_SP ? 4'h4 : $past(fmt_in) == FFC_FMT_DP ?
      4'h8 : 4'ha)) else $error("size");
   a_xp_int_bit: assert property (
      unpack_in && fmt_in == FFC_FMT_XP |=>
      unp_out.signif == $past(mem_in[63:0])) else $error("xp");
   a_sp_zero: assert property (s && e == 8'h00 |=>
      !unp_out.signif[63]) else $error("int bit");
   a_sp_inf: assert property (s && mem_in[30:0] == 31'h7f800000 |=>
      cls_out == FFC_CLS_INF && unp_vld_out) else $error("inf");
   a_pack_bias: assert property (pack_in && fmt_in == FFC_FMT_SP &&
      unp_in.signif[63] |=> mem_out.data[30:23] ==
      8'($past(unp_in.exp_unb) + 16'h007f)) else $error("pack bias");
endmodule // ffc_chk
bind ffc_codec ffc_chk chk (.*);
`default_nettype wire

// ### sim/ffc_dp_model.sv
`timescale 1ns/10ps
`default_nettype none
module ffc_dp_model (
   input  wire logic              clock_in, // Core clock.
   output var  logic              u_out,    // Unpack request.
   output var  logic              p_out,    // Pack request.
   output var  ffc_pkg::ffc_fmt_e f_out,    // Format.
   output var  logic [79:0]       m_out,    // Stored image.
   output var  ffc_pkg::ffc_unp_s n_out     // Operand to pack.
);
   import ffc_pkg::*;
   initial begin
      {u_out, p_out, m_out, n_out} = '0;
      f_out = FFC_FMT_SP;
   end
   // One request held over exactly one taking edge; stale image inverted, operand to pack kept.
   task automatic go(input logic [1:0] up, input ffc_fmt_e f,
      input logic [79:0] m, input ffc_unp_s n);
      @(posedge clock_in);
      #1 {u_out, p_out, m_out, n_out} = {up, m, n};
      f_out = f;
      @(posedge clock_in);
      #1 {u_out, p_out} = 2'b00;
      m_out = ~m;
   endtask
endmodule // ffc_dp_model
`default_nettype wire

// ### sim/tb_float_format_codec.sv
`timescale 1ns/10ps
`default_nettype none
module tb_float_format_codec;
   import ffc_pkg::*;
   localparam ffc_unp_s one_v = {1'b0, 16'h0, 64'h8000000000000000};
   logic        clock_in, resetn_in, u, p, uv, pv;
   logic [79:0] m;
   ffc_fmt_e    f;
   ffc_unp_s    n, uo;
   ffc_cls_e    c;
   ffc_mem_s    mo;
   int          num_errors = 0;
   int          checks = 0;
   ffc_dp_model dp (.clock_in(clock_in), .u_out(u), .p_out(p), .f_out(f),
      .m_out(m), .n_out(n));
   ffc_codec uut (.clock_in(clock_in), .resetn_in(resetn_in), .unpack_in(u),
      .fmt_in(f), .mem_in(m), .pack_in(p), .unp_in(n), .unp_out(uo),
      .cls_out(c), .unp_vld_out(uv), .mem_out(mo), .pack_vld_out(pv));
   task automatic chk(input logic [79:0] g, x);
      checks++;
      if (g !== x) begin
         num_errors++;
         $display("[ERR] %0t got %h want %h", $time, g, x);
      end
   endtask
   task automatic test_done;
      if (num_errors == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic un(input ffc_fmt_e t, input logic [79:0] w, ffc_cls_e k);
      dp.go(2'b10, t, w, '0);
      chk(uv, 1'b1);
      chk(c, k);
      chk(uo.signif[63], k > FFC_CLS_DENORM);
   endtask
   task automatic pk(input ffc_fmt_e t, input ffc_unp_s v,
      input logic [79:0] d, input logic [3:0] z);
      dp.go(2'b01, t, '0, v);
      chk(pv, 1'b1);
      chk(mo.nbytes, z);
      chk(mo.data & ~(~80'h0 << 8 * z), d);
   endtask
   task automatic t_unpack;
      un(FFC_FMT_DP, 80'h4000000000000000, FFC_CLS_NORMAL);
      chk(uo.exp_unb, 16'h1);
      un(FFC_FMT_XP, 80'h4000_8000000000000000, FFC_CLS_NORMAL);
      chk(uo.exp_unb, 16'h1);
      un(FFC_FMT_SP, 80'h3f800000, FFC_CLS_NORMAL);
      chk(uo.exp_unb, 16'h0);
      chk(uo.signif, 64'h8000000000000000);
      un(FFC_FMT_SP, 80'h7fa00000, FFC_CLS_SNAN);
      un(FFC_FMT_SP, 80'h7fc00000, FFC_CLS_QNAN);
      un(FFC_FMT_SP, 80'hffc00000, FFC_CLS_INDEF);
      un(FFC_FMT_SP, 80'h7f800000, FFC_CLS_INF);
      un(FFC_FMT_SP, 80'h80000001, FFC_CLS_DENORM);
      un(FFC_FMT_SP, 80'h80000000, FFC_CLS_ZERO);
   endtask
   task automatic t_pack;
      pk(FFC_FMT_SP, one_v, 80'h3f800000, 4'h4);
      pk(FFC_FMT_DP, {1'b1, 16'h1, 64'hc000000000000000},
         80'hc008000000000000, 4'h8);
      pk(FFC_FMT_XP, one_v, 80'h3fff_8000000000000000, 4'ha);
   endtask
   initial begin
      clock_in = 1'b0;
      forever #20 clock_in = ~clock_in;
   end
   initial begin
      resetn_in = 1'b0;
      repeat (3) @(posedge clock_in);
      #1 resetn_in = 1'b1;
      chk(uv, 1'b0);
      t_unpack;
      t_pack;
      test_done;
   end
endmodule // tb_float_format_codec
`default_nettype wire
